// >>> lpfd_pkg.sv
// Shared constants and types of the position frame decoder pair.
// Assumes both ends and the link interface compile after this package.
package lpfd_pkg;

   // ===========================================================
   // Frame identifiers and fixed command bytes
   localparam logic [7:0] LPFD_FULL_ID     = 8'h3C; // Master request id
   localparam logic [7:0] LPFD_APP_CMD     = 8'h80; // Application command
   localparam logic [6:0] LPFD_POS_CMD     = 7'h0B; // Full position code
   localparam logic [1:0] LPFD_S2_LEN_BITS = 2'h2;  // Id bits 5:4, 4 bytes

   // ===========================================================
   // Data byte counts per frame format
   localparam logic [3:0] LPFD_FULL_LEN = 4'h8;
   localparam logic [3:0] LPFD_S1_LEN   = 4'h2;
   localparam logic [3:0] LPFD_S2_LEN   = 4'h4;
   localparam logic [3:0] LPFD_MAX_LEN  = 4'h8;

   // ===========================================================
   // Field positions inside short and full frame address bytes
   localparam int LPFD_BROAD_BIT  = 4;  // Broadcast or fixed one
   localparam int LPFD_SPOS_MSB   = 7;  // Set-point bits 10:8 at 7:5
   localparam int LPFD_SPOS_LSB   = 5;
   localparam int LPFD_ADDR_FLAG  = 7;  // Set bit of full address bytes

   // ===========================================================
   // Values after reset
   localparam logic [7:0]  LPFD_BYTE_RST = 8'h00;
   localparam logic [15:0] LPFD_POS_RST  = 16'h0000;

   // Frame formats the master can send
   typedef enum logic [1:0] {
      LPFD_KIND_FULL,
      LPFD_KIND_SHORT1,
      LPFD_KIND_SHORT2
   } lpfd_kind_t;

   // One step of the classic checksum: 8-bit sum with end-around carry
   function automatic logic [7:0] lpfd_csum_add(input logic [7:0] acc,
                                                 input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, acc} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

endpackage

// >>> lpfd_link_if.sv
// Byte-level link between the frame master and the frame decoder.
// Assumes both ends share one clock; master drives, decoder listens.
`timescale 1ns/1ns
`default_nettype none
interface lpfd_link_if;
   logic       byte_valid; // A byte is on the link this cycle
   logic       byte_first; // Byte is the protected identifier
   logic       byte_last;  // Byte is the checksum
   logic [7:0] byte_data;

   // Master end drives, device end listens
   modport master (output byte_valid, output byte_first,
                   output byte_last, output byte_data);
   modport device (input byte_valid, input byte_first,
                   input byte_last, input byte_data);
endinterface
`default_nettype wire

// >>> lpfd_id_parity.sv
// Builds a protected identifier from a 6-bit identifier.
// Pure combinational; used by both link ends.
`timescale 1ns/1ns
`default_nettype none
module lpfd_id_parity (
   // Identifier in
   input  wire logic [5:0] id_in,
   // Identifier with parity bits 7:6
   output logic      [7:0] pid_out
);
   // Even parity on 0,1,2,4 and odd parity on 1,3,4,5
   assign pid_out = {~(id_in[1] ^ id_in[3] ^ id_in[4] ^ id_in[5]),
                     id_in[0] ^ id_in[1] ^ id_in[2] ^ id_in[4],
                     id_in};
endmodule
`default_nettype wire

// >>> lpfd_master.sv
// Master end: turns position requests into link frames.
// Assumes one byte per enabled cycle is acceptable to the device end.
`timescale 1ns/1ns
`default_nettype none
module lpfd_master (
   // Clock, reset, enable
   input  wire logic              sys_clk_in,
   input  wire logic              arst_n_in,
   input  wire logic              ce_in,
   // Request side
   input  wire logic              req_valid_in,
   output logic                   req_ready_out,
   input  wire lpfd_pkg::lpfd_kind_t req_kind_in,
   input  wire logic [5:0]        req_id_in,
   input  wire logic              req_broad_in,
   input  wire logic [6:0]        req_addr1_in,
   input  wire logic [6:0]        req_addr2_in,
   input  wire logic [15:0]       req_pos1_in,
   input  wire logic [15:0]       req_pos2_in,
   output logic                   sent_out,
   // Link
   lpfd_link_if.master            link
);
   typedef enum logic {LPFD_M_IDLE, LPFD_M_SEND} lpfd_mstate_t;

   lpfd_mstate_t state;
   logic [7:0]   frame [0:8];
   logic [3:0]   frame_len;
   logic [3:0]   idx;
   logic [7:0]   acc;
   logic [5:0]   raw_id;
   logic [7:0]   pid;
   logic         take;

   // ===========================================================
   // Identifier length bits forced per short format
   always_comb begin
      case (req_kind_in)
         lpfd_pkg::LPFD_KIND_SHORT1: raw_id = {1'b0, req_id_in[4:0]};
         lpfd_pkg::LPFD_KIND_SHORT2:
            raw_id = {lpfd_pkg::LPFD_S2_LEN_BITS, req_id_in[3:0]};
         default:                    raw_id = req_id_in;
      endcase
   end

   lpfd_id_parity u_parity (
      .id_in   (raw_id),
      .pid_out (pid)
   );

   assign take = ce_in && req_valid_in && (state == LPFD_M_IDLE);

   // ===========================================================
   // Frame image built when a request is taken
   always_ff @(posedge sys_clk_in) begin
      if (take) begin
         frame[5] <= lpfd_pkg::LPFD_BYTE_RST;
         frame[6] <= lpfd_pkg::LPFD_BYTE_RST;
         frame[7] <= lpfd_pkg::LPFD_BYTE_RST;
         frame[8] <= lpfd_pkg::LPFD_BYTE_RST;
         case (req_kind_in)
            lpfd_pkg::LPFD_KIND_SHORT1: begin
               frame[0] <= pid; // [RULE16]
               frame[1] <= {req_pos1_in[10:8], req_broad_in,
                            req_addr1_in[3:0]}; // [RULE10]
               frame[2] <= req_pos1_in[7:0];
               frame[3] <= lpfd_pkg::LPFD_BYTE_RST;
               frame[4] <= lpfd_pkg::LPFD_BYTE_RST;
            end
            lpfd_pkg::LPFD_KIND_SHORT2: begin
               frame[0] <= pid; // [RULE16]
               frame[1] <= {req_pos1_in[10:8], 1'b1,
                            req_addr1_in[3:0]}; // [RULE12]
               frame[2] <= req_pos1_in[7:0];
               frame[3] <= {req_pos2_in[10:8], 1'b1, req_addr2_in[3:0]};
               frame[4] <= req_pos2_in[7:0];
            end
            default: begin
               frame[0] <= lpfd_pkg::LPFD_FULL_ID; // [RULE1]
               frame[1] <= lpfd_pkg::LPFD_APP_CMD;
               frame[2] <= {1'b1, lpfd_pkg::LPFD_POS_CMD};
               frame[3] <= {1'b1, req_addr1_in}; // [RULE2]
               frame[4] <= req_pos1_in[15:8];
               frame[5] <= req_pos1_in[7:0];
               frame[6] <= {1'b1, req_addr2_in};
               frame[7] <= req_pos2_in[15:8];
               frame[8] <= req_pos2_in[7:0];
            end
         endcase
      end
   end

   // ===========================================================
   // Sequencer: identifier, data bytes, then checksum
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state     <= LPFD_M_IDLE;
         frame_len <= 4'h0;
         idx       <= 4'h0;
         acc       <= lpfd_pkg::LPFD_BYTE_RST;
      end else if (ce_in) begin
         case (state)
            LPFD_M_IDLE: begin
               if (req_valid_in) begin
                  state <= LPFD_M_SEND;
                  idx   <= 4'h0;
                  acc   <= lpfd_pkg::LPFD_BYTE_RST;
                  case (req_kind_in)
                     lpfd_pkg::LPFD_KIND_SHORT1:
                        frame_len <= lpfd_pkg::LPFD_S1_LEN;
                     lpfd_pkg::LPFD_KIND_SHORT2:
                        frame_len <= lpfd_pkg::LPFD_S2_LEN;
                     default: frame_len <= lpfd_pkg::LPFD_FULL_LEN;
                  endcase
               end
            end
            LPFD_M_SEND: begin
               if (idx > frame_len) begin
                  state <= LPFD_M_IDLE;
               end
               if (idx != 4'h0 && idx <= frame_len) begin
                  acc <= lpfd_pkg::lpfd_csum_add(acc, frame[idx]);
               end
               idx <= idx + 4'h1;
            end
            default: state <= LPFD_M_IDLE;
         endcase
      end
   end

   // ===========================================================
   // Link and request outputs, all registered
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         link.byte_valid <= 1'b0;
         link.byte_first <= 1'b0;
         link.byte_last  <= 1'b0;
         link.byte_data  <= lpfd_pkg::LPFD_BYTE_RST;
         req_ready_out   <= 1'b0;
         sent_out        <= 1'b0;
      end else if (ce_in) begin
         req_ready_out   <= (state == LPFD_M_IDLE) && !req_valid_in;
         link.byte_valid <= (state == LPFD_M_SEND) && (idx <= frame_len + 4'h1);
         link.byte_first <= (state == LPFD_M_SEND) && (idx == 4'h0);
         link.byte_last  <= (state == LPFD_M_SEND) && (idx == frame_len + 4'h1);
         sent_out        <= (state == LPFD_M_SEND) && (idx == frame_len + 4'h1);
         if (state == LPFD_M_SEND && idx == frame_len + 4'h1) begin
            link.byte_data <= ~acc; // Inverted sum over data bytes
         end else if (state == LPFD_M_SEND && idx <= frame_len) begin
            link.byte_data <= frame[idx];
         end
      end
   end

endmodule
`default_nettype wire

// >>> lpfd_decoder.sv
// Device end: decodes position frames into a set-point for the
// position controller. Assumes the link comes from logic on sys_clk_in.
//
// Overview of operation
// [RULE1] Full frame: id 0x3C, 0x80, then 0x8B
// [RULE2] Full frame: flagged address, then set-point high, low
// [RULE3] Full set-point signed 16-bit, own address selects
// [RULE4] Short set-point is 11 bits of half steps
// [RULE5] Short moves keep resolution, end on half steps
// [RULE6] Short frames carry 4-bit addresses, sixteen nodes
// [RULE7] Short address compares with stored address low bits
// [RULE8] Hardwired address inputs recommended tied high
// [RULE9] Blocked commands from priority logic are ignored
// [RULE10] One-motor short: set-point high, broadcast, address
// [RULE11] Broadcast flag zero: every node accepts set-point
// [RULE12] Two-motor short: four bytes, flag bit set
// [RULE13] Short address is physical address low bits
// [RULE14] Short set-point is signed, bit ten sign
// [RULE15] Short frames only on their allocated identifiers
// [RULE16] Short identifiers: parity bits, length bits checked
// [RULE17] Bad checksum discards the frame
`timescale 1ns/1ns
`default_nettype none
module lpfd_decoder (
   // Clock, reset, enable
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        ce_in,
   // Link
   lpfd_link_if.device      link,
   // Node configuration
   input  wire logic [7:0]  otp_physical_address_in,
   input  wire logic        hardwired_address_input_0_in,
   input  wire logic        hardwired_address_input_1_in,
   input  wire logic        hardwired_address_input_2_in,
   input  wire logic [5:0]  short1_id_in,
   input  wire logic [5:0]  short2_id_in,
   input  wire logic [1:0]  stepping_resolution_in,
   input  wire logic        command_blocked_in,
   // Set-point to the position controller
   output logic             setpoint_valid_out,
   output logic [15:0]      setpoint_out,
   output logic             setpoint_short_out,
   output logic             frame_error_out
);
   typedef enum logic [1:0] {
      LPFD_D_IDLE,
      LPFD_D_RECV,
      LPFD_D_EVAL
   } lpfd_dstate_t;

   lpfd_dstate_t state;
   logic [7:0]   data_q [0:7];
   logic [7:0]   id_q;
   logic [3:0]   cnt;
   logic [7:0]   acc;
   logic [2:0]   hw_meta;
   logic [2:0]   hw_sync;
   logic [7:0]   pid;
   logic [6:0]   node_addr;
   logic [3:0]   short_addr;
   logic         is_full;
   logic         is_s1;
   logic         is_s2;
   logic         next_hit;
   logic         next_short;
   logic [15:0]  next_full_pos;
   logic [10:0]  next_short_pos;
   logic [15:0]  short_ext;
   logic [15:0]  short_scaled;

   // ===========================================================
   // Hardwired address pins pass two flip-flops
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hw_meta <= 3'h0;
         hw_sync <= 3'h0;
      end else if (ce_in) begin
         hw_meta <= {hardwired_address_input_2_in,
                     hardwired_address_input_1_in,
                     hardwired_address_input_0_in};
         hw_sync <= hw_meta;
      end
   end

   // Full address: hardwired bits over the stored low bits
   assign node_addr  = {hw_sync, otp_physical_address_in[3:0]}; // [RULE8]
   assign short_addr = otp_physical_address_in[3:0]; // [RULE7] [RULE13]

   // ===========================================================
   // Byte collection and running checksum
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= LPFD_D_IDLE;
         id_q  <= lpfd_pkg::LPFD_BYTE_RST;
         cnt   <= 4'h0;
         acc   <= lpfd_pkg::LPFD_BYTE_RST;
      end else if (ce_in) begin
         case (state)
            LPFD_D_EVAL: state <= LPFD_D_IDLE;
            default: begin
               if (link.byte_valid && link.byte_first) begin
                  state <= LPFD_D_RECV;
                  id_q  <= link.byte_data;
                  cnt   <= 4'h0;
                  acc   <= lpfd_pkg::LPFD_BYTE_RST;
               end else if (link.byte_valid && state == LPFD_D_RECV) begin
                  if (link.byte_last) begin
                     // Evaluate only with a good checksum
                     state <= (link.byte_data == ~acc) ?
                              LPFD_D_EVAL : LPFD_D_IDLE; // [RULE17]
                  end else if (cnt == lpfd_pkg::LPFD_MAX_LEN) begin
                     state <= LPFD_D_IDLE; // Overlong frame dropped
                  end else begin
                     acc <= lpfd_pkg::lpfd_csum_add(acc, link.byte_data);
                     cnt <= cnt + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // ===========================================================
   // Data byte store
   always_ff @(posedge sys_clk_in) begin
      if (ce_in && state == LPFD_D_RECV && link.byte_valid &&
          !link.byte_first && !link.byte_last &&
          cnt != lpfd_pkg::LPFD_MAX_LEN) begin
         data_q[cnt[2:0]] <= link.byte_data;
      end
   end

   // ===========================================================
   // Identifier protection check
   lpfd_id_parity u_parity (
      .id_in   (id_q[5:0]),
      .pid_out (pid)
   );

   // ===========================================================
   // Frame format recognition
   always_comb begin
      is_full = (id_q == lpfd_pkg::LPFD_FULL_ID) &&
                (cnt == lpfd_pkg::LPFD_FULL_LEN) &&
                (data_q[0] == lpfd_pkg::LPFD_APP_CMD) &&
                (data_q[1] == {1'b1, lpfd_pkg::LPFD_POS_CMD}) && // [RULE1]
                data_q[2][lpfd_pkg::LPFD_ADDR_FLAG] &&
                data_q[5][lpfd_pkg::LPFD_ADDR_FLAG]; // [RULE2]
      is_s1   = (pid == id_q) && !id_q[5] && // [RULE16]
                (id_q[5:0] == short1_id_in) && // [RULE15]
                (cnt == lpfd_pkg::LPFD_S1_LEN);
      is_s2   = (pid == id_q) &&
                (id_q[5:4] == lpfd_pkg::LPFD_S2_LEN_BITS) && // [RULE16]
                (id_q[5:0] == short2_id_in) && // [RULE15]
                (cnt == lpfd_pkg::LPFD_S2_LEN) &&
                data_q[0][lpfd_pkg::LPFD_BROAD_BIT] &&
                data_q[2][lpfd_pkg::LPFD_BROAD_BIT]; // [RULE12]
   end

   // ===========================================================
   // Address match and set-point selection
   always_comb begin
      next_hit       = 1'b0;
      next_short     = 1'b0;
      next_full_pos  = lpfd_pkg::LPFD_POS_RST;
      next_short_pos = 11'h000;
      if (is_full) begin
         if (data_q[2][6:0] == node_addr) begin
            next_hit      = 1'b1;
            next_full_pos = {data_q[3], data_q[4]}; // [RULE3]
         end else if (data_q[5][6:0] == node_addr) begin
            next_hit      = 1'b1;
            next_full_pos = {data_q[6], data_q[7]}; // [RULE3]
         end
      end else if (is_s1) begin
         next_short     = 1'b1;
         next_short_pos = {data_q[0][lpfd_pkg::LPFD_SPOS_MSB:
                                     lpfd_pkg::LPFD_SPOS_LSB],
                           data_q[1]}; // [RULE10]
         // Zero flag is broadcast, one asks for an address match
         next_hit = !data_q[0][lpfd_pkg::LPFD_BROAD_BIT] || // [RULE11]
                    (data_q[0][3:0] == short_addr); // [RULE6]
      end else if (is_s2) begin
         next_short = 1'b1;
         if (data_q[0][3:0] == short_addr) begin // [RULE6]
            next_hit       = 1'b1;
            next_short_pos = {data_q[0][lpfd_pkg::LPFD_SPOS_MSB:
                                        lpfd_pkg::LPFD_SPOS_LSB],
                              data_q[1]}; // [RULE12]
         end else if (data_q[2][3:0] == short_addr) begin
            next_hit       = 1'b1;
            next_short_pos = {data_q[2][lpfd_pkg::LPFD_SPOS_MSB:
                                        lpfd_pkg::LPFD_SPOS_LSB],
                              data_q[3]}; // [RULE12]
         end
      end
   end

   // ===========================================================
   // Half-step value scaled to the programmed resolution
   assign short_ext    = {{5{next_short_pos[10]}}, next_short_pos}; // [RULE14]
   assign short_scaled = short_ext << stepping_resolution_in; // [RULE4] [RULE5]

   // ===========================================================
   // Registered set-point hand-off
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         setpoint_valid_out <= 1'b0;
         setpoint_out       <= lpfd_pkg::LPFD_POS_RST;
         setpoint_short_out <= 1'b0;
      end else if (ce_in) begin
         setpoint_valid_out <= 1'b0;
         if (state == LPFD_D_EVAL && next_hit &&
             !command_blocked_in) begin // [RULE9]
            setpoint_valid_out <= 1'b1;
            setpoint_short_out <= next_short;
            setpoint_out       <= next_short ? short_scaled : next_full_pos;
         end
      end
   end

   // ===========================================================
   // Checksum failure pulse
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         frame_error_out <= 1'b0;
      end else if (ce_in) begin
         frame_error_out <= (state == LPFD_D_RECV) && link.byte_valid &&
                            !link.byte_first && link.byte_last &&
                            (link.byte_data != ~acc); // [RULE17]
      end
   end

endmodule
`default_nettype wire

// >>> lpfd_checker.sv
// Assertions on the link between the frame master and the decoder.
// Assumes one byte per enabled cycle and instantiation beside the link.
`timescale 1ns/1ns
`default_nettype none
module lpfd_checker (
   // Clock and reset
   input wire logic       sys_clk_in,
   input wire logic       arst_n_in,
   // Link
   input wire logic       byte_valid,
   input wire logic       byte_first,
   input wire logic       byte_last,
   input wire logic [7:0] byte_data
);
   // ==========================================================
   // Frame starts by format
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   logic full;
   logic s1;
   logic s2;
   assign full = byte_first && byte_data == 8'h3C;
   assign s1   = byte_first && !byte_data[5];
   assign s2   = byte_first && byte_data[5:4] == 2'h2;
   // ==========================================================
   // Frame layout
   property p_full_cmd;
      full |=> byte_data == 8'h80 ##1 byte_data == 8'h8B;
   endproperty
   a_full_cmd: assert property (p_full_cmd) else $error("full cmd");
   property p_full_addr;
      full |-> ##3 byte_data[7] ##3 byte_data[7];
   endproperty
   a_full_addr: assert property (p_full_addr) else $error("addr");
   property p_full_len; full |-> ##9 byte_last; endproperty
   a_full_len: assert property (p_full_len) else $error("full len");
   property p_s1_len; s1 |-> ##3 byte_last; endproperty
   a_s1_len: assert property (p_s1_len) else $error("s1 len");
   property p_s2_len; s2 |-> ##5 byte_last; endproperty
   a_s2_len: assert property (p_s2_len) else $error("s2 len");
   property p_s2_flag; s2 |-> ##1 byte_data[4] ##2 byte_data[4]; endproperty
   a_s2_flag: assert property (p_s2_flag) else $error("s2 flag");
   property p_parity;
      byte_first && !full |-> byte_data[7] == ~^{byte_data[5:3],
         byte_data[1]} && byte_data[6] == ^{byte_data[4], byte_data[2:0]};
   endproperty
   a_parity: assert property (p_parity) else $error("id parity");
   property p_gap; byte_last |=> !byte_valid; endproperty
   a_gap: assert property (p_gap) else $error("frame gap");
   // Main frame kinds seen
   c_full: cover property (full ##9 byte_last);
   c_s1: cover property (s1 ##3 byte_last);
   c_s2: cover property (s2 ##5 byte_last);
endmodule
`default_nettype wire

// >>> tb.sv
// Testbench of the frame master and decoder pair plus a fault link.
// Assumes package, link, parity, master and decoder compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ==========================================================
   // Stimulus and observed signals
   localparam lpfd_pkg::lpfd_kind_t kf = lpfd_pkg::LPFD_KIND_FULL;
   localparam lpfd_pkg::lpfd_kind_t k1 = lpfd_pkg::LPFD_KIND_SHORT1;
   localparam lpfd_pkg::lpfd_kind_t k2 = lpfd_pkg::LPFD_KIND_SHORT2;
   logic                 sys_clk_in = 1'h0;
   logic                 arst_n_in  = 1'h0;
   logic                 req_valid  = 1'h0;
   lpfd_pkg::lpfd_kind_t req_kind   = kf;
   logic [5:0]           req_id     = 6'h0;
   logic                 req_broad  = 1'h0;
   logic [6:0]           a1         = 7'h0;
   logic [6:0]           a2         = 7'h0;
   logic [15:0]          p1         = 16'h0;
   logic [15:0]          p2         = 16'h0;
   logic [1:0]           res        = 2'h0;
   logic                 blk        = 1'h0;
   logic [5:0]           s1_id      = 6'h05;
   logic [5:0]           s2_id      = 6'h22;
   logic [7:0]           otp        = 8'h05;
   logic [2:0]           hw         = 3'h7;
   logic                 ready, snt, sv, sh, err, sv2, sh2, err2;
   logic [15:0]          sp, sp2;
   int                   n_mismatch = 0;
   int                   total_checks = 0;
   lpfd_link_if link (), link2 ();
   // Clock
   always #2 sys_clk_in = ~sys_clk_in;
   // Design ends and the fault-link decoder
   lpfd_master lpfd_master_inst (.sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in), .ce_in(1'h1), .req_valid_in(req_valid),
      .req_ready_out(ready), .req_kind_in(req_kind), .req_id_in(req_id),
      .req_broad_in(req_broad), .req_addr1_in(a1), .req_addr2_in(a2),
      .req_pos1_in(p1), .req_pos2_in(p2), .sent_out(snt), .link(link));
   lpfd_decoder lpfd_decoder_inst (.sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in), .ce_in(1'h1), .link(link),
      .otp_physical_address_in(otp), .hardwired_address_input_0_in(hw[0]),
      .hardwired_address_input_1_in(hw[1]),
      .hardwired_address_input_2_in(hw[2]), .short1_id_in(s1_id),
      .short2_id_in(s2_id), .stepping_resolution_in(res),
      .command_blocked_in(blk), .setpoint_valid_out(sv),
      .setpoint_out(sp), .setpoint_short_out(sh), .frame_error_out(err));
   lpfd_decoder lpfd_decoder_inst2 (.sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in), .ce_in(1'h1), .link(link2),
      .otp_physical_address_in(otp), .hardwired_address_input_0_in(hw[0]),
      .hardwired_address_input_1_in(hw[1]),
      .hardwired_address_input_2_in(hw[2]), .short1_id_in(s1_id),
      .short2_id_in(s2_id), .stepping_resolution_in(res),
      .command_blocked_in(blk), .setpoint_valid_out(sv2),
      .setpoint_out(sp2), .setpoint_short_out(sh2), .frame_error_out(err2));
   lpfd_checker lpfd_checker_inst (.sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in), .byte_valid(link.byte_valid),
      .byte_first(link.byte_first), .byte_last(link.byte_last),
      .byte_data(link.byte_data));
   // ==========================================================
   // Compare and closing tasks
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Protected identifier worked out from the six id bits
   function automatic logic [7:0] pid_of(input logic [5:0] i);
      return {~^{i[5:3], i[1]}, ^{i[4], i[2:0]}, i};
   endfunction
   // One master request, then watch the decoder for a set-point
   task automatic run(input lpfd_pkg::lpfd_kind_t k, input logic b,
      input logic [6:0] x1, input logic [6:0] x2, input logic [15:0] y1,
      input logic [15:0] y2, input logic ev, input logic [15:0] es);
      logic        got = 1'h0, seen = 1'h0;
      logic [15:0] val = 16'h0;
      @(negedge sys_clk_in);
      chk1(ready, 1'h1);
      req_kind = k;
      req_id = (k == k2) ? 6'h22 : 6'h05;
      {req_broad, a1, a2, p1, p2} = {b, x1, x2, y1, y2};
      req_valid = 1'h1;
      @(negedge sys_clk_in);
      req_valid = 1'h0;
      repeat (20) begin
         @(negedge sys_clk_in);
         seen = seen | (snt === 1'h1);
         chk1(err, 1'h0);
         if (sv === 1'h1) begin
            got = 1'h1;
            val = sp;
         end
      end
      chk1(got, ev);
      chk1(seen, 1'h1);
      if (ev) begin
         chk16(val, es);
         chk1(sh, k != kf);
      end
   endtask
   // Hand-made short frame on the fault link, checksum spoilt by cx
   task automatic raw(input logic [7:0] pid, input logic [7:0] d1,
      input logic [7:0] cx, output logic e, output logic v);
      logic [8:0] s;
      logic [7:0] b [4];
      s = {1'h0, d1};
      b = '{pid, d1, 8'h00, ~(s[7:0] + {7'h00, s[8]}) ^ cx};
      e = 1'h0;
      v = 1'h0;
      for (int i = 0; i < 4; i++) begin
         @(negedge sys_clk_in);
         link2.byte_valid = 1'h1;
         link2.byte_first = (i == 0);
         link2.byte_last = (i == 3);
         link2.byte_data = b[i];
      end
      repeat (6) begin
         @(negedge sys_clk_in);
         link2.byte_valid = 1'h0;
         link2.byte_last = 1'h0;
         e = e | (err2 === 1'h1);
         v = v | (sv2 === 1'h1);
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_full();
      run(kf, 1'h0, 7'h11, 7'h75, 16'h1234, 16'h8001, 1'h1, 16'h8001);
      run(kf, 1'h0, 7'h75, 7'h75, 16'h7FFF, 16'h1, 1'h1, 16'h7FFF);
      run(kf, 1'h0, 7'h15, 7'h05, 16'h1, 16'h2, 1'h0, 16'h0);
   endtask
   task automatic t_short1();
      run(k1, 1'h1, 7'h05, 7'h0, 16'h400, 16'h0, 1'h1, 16'hFC00);
      run(k1, 1'h0, 7'h0A, 7'h0, 16'h3FF, 16'h0, 1'h1, 16'h03FF);
      run(k1, 1'h1, 7'h0A, 7'h0, 16'h123, 16'h0, 1'h0, 16'h0);
      s1_id = 6'h06;
      run(k1, 1'h1, 7'h05, 7'h0, 16'h1, 16'h0, 1'h0, 16'h0);
      s1_id = 6'h05;
   endtask
   task automatic t_short2();
      res = 2'h1;
      run(k2, 1'h0, 7'h03, 7'h05, 16'h10, 16'h7FF, 1'h1, 16'hFFFE);
      run(k2, 1'h0, 7'h05, 7'h05, 16'h200, 16'h1, 1'h1, 16'h0400);
      res = 2'h3;
      run(k2, 1'h0, 7'h0F, 7'h05, 16'h0, 16'h3, 1'h1, 16'h0018);
      run(k2, 1'h0, 7'h0F, 7'h0E, 16'h1, 16'h3, 1'h0, 16'h0);
      res = 2'h0;
   endtask
   task automatic t_block();
      blk = 1'h1;
      run(k1, 1'h1, 7'h05, 7'h0, 16'h5, 16'h0, 1'h0, 16'h0);
      run(kf, 1'h0, 7'h75, 7'h0, 16'h5, 16'h0, 1'h0, 16'h0);
      blk = 1'h0;
   endtask
   task automatic t_fault();
      logic e, v;
      raw(pid_of(6'h05), 8'h35, 8'h00, e, v);
      chk1(v, 1'h1);
      chk16(sp2, 16'h0100);
      raw(pid_of(6'h05), 8'h35, 8'h01, e, v);
      chk1(e, 1'h1);
      chk1(v, 1'h0);
      raw(pid_of(6'h05) ^ 8'h40, 8'h35, 8'h00, e, v);
      chk1(v, 1'h0);
   endtask
   // Reset, then the scenarios in turn
   initial begin
      link2.byte_valid = 1'h0;
      link2.byte_first = 1'h0;
      link2.byte_last = 1'h0;
      link2.byte_data = 8'h00;
      repeat (5) @(negedge sys_clk_in);
      arst_n_in = 1'h1;
      t_full();
      t_short1();
      t_short2();
      t_block();
      t_fault();
      end_of_test();
   end
   // Watchdog against a hang
   initial begin
      #20000;
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
